// ===== pkg/pma_rw_cfg.svh
// constants of the analog setting write and read-back block
// assumes it is included by bare name from the package and the design files
//
// How it works
// - dc-gain write: 3 bits shared, else per channel
// - output-swing read-back, 3 bits per channel
// - pre-tap read-back, 5 bits per channel
// - first post-tap read-back, 5 bits per channel
// - second post-tap read-back, 5 bits per channel
// - equalization read-back, 4 bits per channel
// - dc-gain read-back, 3 bits per channel
// - a write loads every channel's registers; in shared mode with logical addressing, only chan_addr_in's
`ifndef PMA_RW_CFG_SVH
`define PMA_RW_CFG_SVH

// ****************************************
// channel count and field widths
// ****************************************
`define NUM_CH 4
`define CH_IDX_W 2
`define SWING_W 3
`define TAP_W 5
`define EQ_W 4
`define DCG_W 3

// ****************************************
// reset values and legal codes
// ****************************************
`define SWING_RST 3'h0
`define TAP_RST 5'h00
`define EQ_RST 4'h0
`define DCG_RST 3'h0
`define DCG_MAX 3'h4

// ****************************************
// write sequencer state codes, one-hot
// ****************************************
`define ST_IDLE_CODE 2'h1
`define ST_COMMIT_CODE 2'h2

`endif

// ===== pkg/pma_rw_pkg.sv
// types of the analog setting write and read-back block
// assumes the constants header sits in the include path
`default_nettype none
`include "pma_rw_cfg.svh"
package pma_rw_pkg;
    // write sequencer: take the request, then commit to the channels
    typedef enum logic [1:0] {
        ST_IDLE = `ST_IDLE_CODE,
        ST_COMMIT = `ST_COMMIT_CODE
    } wr_state_t;
endpackage : pma_rw_pkg
`default_nettype wire

// ===== src/chan_setting_reg.sv
// one channel's analog control registers: swing, three taps, eq, dc gain
// assumes the load strobe and all data come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "pma_rw_cfg.svh"
module chan_setting_reg (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic [`SWING_W-1:0] swing_in,
    input wire logic [`TAP_W-1:0] pre_in,
    input wire logic [`TAP_W-1:0] post1_in,
    input wire logic [`TAP_W-1:0] post2_in,
    input wire logic [`EQ_W-1:0] eq_in,
    input wire logic [`DCG_W-1:0] dcg_in,
    output logic [`SWING_W-1:0] swing_out,
    output logic [`TAP_W-1:0] pre_out,
    output logic [`TAP_W-1:0] post1_out,
    output logic [`TAP_W-1:0] post2_out,
    output logic [`EQ_W-1:0] eq_out,
    output logic [`DCG_W-1:0] dcg_out
);
    // ****************************************
    // held settings
    // ****************************************
    // outputs are the registers themselves, so read-back always shows what is held
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            swing_out <= `SWING_RST;
            pre_out <= `TAP_RST;
            post1_out <= `TAP_RST;
            post2_out <= `TAP_RST;
            eq_out <= `EQ_RST;
            dcg_out <= `DCG_RST;
        end else if (load_in) begin
            swing_out <= swing_in;
            pre_out <= pre_in;
            post1_out <= post1_in;
            post2_out <= post2_in;
            eq_out <= eq_in;
            dcg_out <= dcg_in;
        end
    end
endmodule : chan_setting_reg
`default_nettype wire

// ===== src/pma_analog_setting_rw_ports.sv
// top of the analog setting write and read-back ports
// assumes write strobe, address and data come from controller logic on mclk_in
`timescale 1ns/100ps
`default_nettype none
`include "pma_rw_cfg.svh"
module pma_analog_setting_rw_ports #(
    parameter bit SHARED_CTRL = 1'b0 // 1: one field for all channels
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic write_in, // one-cycle write request
    input wire logic logical_addr_en_in, // shared mode: write only chan_addr_in
    input wire logic [`CH_IDX_W-1:0] chan_addr_in,
    input wire logic [`SWING_W*(SHARED_CTRL ? 1 : `NUM_CH)-1:0] swing_write_in,
    input wire logic [`TAP_W*(SHARED_CTRL ? 1 : `NUM_CH)-1:0] pretap_write_in,
    input wire logic [`TAP_W*(SHARED_CTRL ? 1 : `NUM_CH)-1:0] post1_tap_write_in,
    input wire logic [`TAP_W*(SHARED_CTRL ? 1 : `NUM_CH)-1:0] post2_tap_write_in,
    input wire logic [`EQ_W*(SHARED_CTRL ? 1 : `NUM_CH)-1:0] eq_write_in,
    input wire logic [`DCG_W*(SHARED_CTRL ? 1 : `NUM_CH)-1:0] dcgain_write_in,
    output logic busy_out, // high in the commit cycle
    output logic dcgain_code_err_out, // sticky: an undefined code was written
    output logic [`SWING_W*`NUM_CH-1:0] swing_readback_out,
    output logic [`TAP_W*`NUM_CH-1:0] pretap_readback_out,
    output logic [`TAP_W*`NUM_CH-1:0] post1_tap_readback_out,
    output logic [`TAP_W*`NUM_CH-1:0] post2_tap_readback_out,
    output logic [`EQ_W*`NUM_CH-1:0] eq_readback_out,
    output logic [`DCG_W*`NUM_CH-1:0] dcgain_readback_out
);
    localparam int NW = SHARED_CTRL ? 1 : `NUM_CH; // fields per write input

    // ****************************************
    // request staging
    // ****************************************
    pma_rw_pkg::wr_state_t state_q; // write sequencer
    pma_rw_pkg::wr_state_t state_d;
    logic [`NUM_CH-1:0] mask_q; // channels the staged write reaches
    logic [`NUM_CH-1:0] mask_d;
    logic [`SWING_W*NW-1:0] stg_swing_q;
    logic [`TAP_W*NW-1:0] stg_pre_q;
    logic [`TAP_W*NW-1:0] stg_post1_q;
    logic [`TAP_W*NW-1:0] stg_post2_q;
    logic [`EQ_W*NW-1:0] stg_eq_q;
    logic [`DCG_W*NW-1:0] stg_dcg_q;
    logic err_d;
    wire take = write_in && (state_q == pma_rw_pkg::ST_IDLE);
    wire commit = (state_q == pma_rw_pkg::ST_COMMIT);
    wire [`NUM_CH-1:0] one_ch = `NUM_CH'(1) << chan_addr_in;
    // logical addressing exists only with a shared field
    wire sel_one = SHARED_CTRL && logical_addr_en_in;

    // ****************************************
    // next-state decode
    // ****************************************
    // a request while busy is dropped; the controller spaces them two cycles
    assign state_d = take ? pma_rw_pkg::ST_COMMIT : pma_rw_pkg::ST_IDLE;
    assign mask_d = sel_one ? one_ch : {`NUM_CH{1'b1}};

    // undefined gain codes have no setting; flag them, store them unchanged
    logic dcg_bad; // some written field is above the last legal code
    always_comb begin
        dcg_bad = 1'b0;
        for (int i = 0; i < NW; i++) begin
            if (dcgain_write_in[i*`DCG_W +: `DCG_W] > `DCG_MAX) begin
                dcg_bad = 1'b1;
            end
        end
    end
    assign err_d = dcgain_code_err_out || (take && dcg_bad);

    // sequencer and status flops
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= pma_rw_pkg::ST_IDLE;
            busy_out <= 1'b0;
            dcgain_code_err_out <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_out <= take;
            dcgain_code_err_out <= err_d;
        end
    end

    // staging flops, loaded only on an accepted request
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_q <= '0;
            stg_swing_q <= '0;
            stg_pre_q <= '0;
            stg_post1_q <= '0;
            stg_post2_q <= '0;
            stg_eq_q <= '0;
            stg_dcg_q <= '0;
        end else if (take) begin
            mask_q <= mask_d;
            stg_swing_q <= swing_write_in;
            stg_pre_q <= pretap_write_in;
            stg_post1_q <= post1_tap_write_in;
            stg_post2_q <= post2_tap_write_in;
            stg_eq_q <= eq_write_in;
            stg_dcg_q <= dcgain_write_in;
        end
    end

    // ****************************************
    // per-channel registers
    // ****************************************
    // shared mode fans field 0 out to every channel; else channel i takes field i
    for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
        localparam int F = SHARED_CTRL ? 0 : i; // field index for this channel
        chan_setting_reg u_reg (
            .mclk_in(mclk_in),
            .rstn_in(rstn_in),
            .load_in(commit && mask_q[i]),
            .swing_in(stg_swing_q[F*`SWING_W +: `SWING_W]),
            .pre_in(stg_pre_q[F*`TAP_W +: `TAP_W]),
            .post1_in(stg_post1_q[F*`TAP_W +: `TAP_W]),
            .post2_in(stg_post2_q[F*`TAP_W +: `TAP_W]),
            .eq_in(stg_eq_q[F*`EQ_W +: `EQ_W]),
            .dcg_in(stg_dcg_q[F*`DCG_W +: `DCG_W]),
            // channel i lands at bits i*width, channel 0 lowest
            .swing_out(swing_readback_out[i*`SWING_W +: `SWING_W]),
            .pre_out(pretap_readback_out[i*`TAP_W +: `TAP_W]),
            .post1_out(post1_tap_readback_out[i*`TAP_W +: `TAP_W]),
            .post2_out(post2_tap_readback_out[i*`TAP_W +: `TAP_W]),
            .eq_out(eq_readback_out[i*`EQ_W +: `EQ_W]),
            .dcg_out(dcgain_readback_out[i*`DCG_W +: `DCG_W])
        );
    end

    // ****************************************
    // checks
    // ****************************************
    localparam int LT = `NUM_CH - 1; // last channel
    localparam int LF = SHARED_CTRL ? 0 : `NUM_CH - 1; // its write field

    AST_TAKE_THEN_COMMIT: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (write_in && state_q == pma_rw_pkg::ST_IDLE) |=> busy_out ##1 (!busy_out))
        else $error("accepted write not committed in one cycle");

    AST_PRETAP_CH0: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && mask_d[0]) |-> ##2 (pretap_readback_out[`TAP_W-1:0]
            == $past(pretap_write_in[`TAP_W-1:0], 2)))
        else $error("pre-tap read-back of channel 0 wrong after write");

    AST_POST1_LAST: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && mask_d[LT]) |-> ##2 (post1_tap_readback_out[LT*`TAP_W +: `TAP_W]
            == $past(post1_tap_write_in[LF*`TAP_W +: `TAP_W], 2)))
        else $error("first post-tap read-back of last channel wrong");

    AST_POST2_CH0: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && mask_d[0]) |-> ##2 (post2_tap_readback_out[`TAP_W-1:0]
            == $past(post2_tap_write_in[`TAP_W-1:0], 2)))
        else $error("second post-tap read-back of channel 0 wrong");

    AST_LAST_IN_TOP: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && mask_d[LT]) |-> ##2 (eq_readback_out[LT*`EQ_W +: `EQ_W]
            == $past(eq_write_in[LF*`EQ_W +: `EQ_W], 2)))
        else $error("last channel not in the top read-back bits");

    AST_SWING_HOLD: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (!commit) |=> $stable(swing_readback_out) && $stable(eq_readback_out))
        else $error("read-back changed without a commit");

    AST_DCG_SHARED: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && SHARED_CTRL && !logical_addr_en_in) |-> ##2
            (dcgain_readback_out == {`NUM_CH{$past(dcgain_write_in[`DCG_W-1:0], 2)}}))
        else $error("shared dc-gain field not fanned to all channels");

    AST_DCG_LAST: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && mask_d[LT]) |-> ##2 (dcgain_readback_out[LT*`DCG_W +: `DCG_W]
            == $past(dcgain_write_in[LF*`DCG_W +: `DCG_W], 2)))
        else $error("dc-gain read-back of last channel wrong");

    AST_ONE_CHANNEL: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (take && sel_one && chan_addr_in != `CH_IDX_W'(0)) |-> ##2
            $stable(pretap_readback_out[`TAP_W-1:0]))
        else $error("addressed write disturbed channel 0");
endmodule : pma_analog_setting_rw_ports
`default_nettype wire

// ===== test/chan_reg_model.sv
// behavioural model of the channel analog control registers
// assumes write data is packed as {dcg, eq, post2, post1, pre, swing}, channel 0 lowest
`timescale 1ns/100ps
`default_nettype none
module chan_reg_model (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic write_in,
    input wire logic [99:0] data_in,
    output logic [99:0] exp_out
);
    // ****************************************
    // register image
    // ****************************************
    logic took_q; // a write was taken last cycle, so this one is dropped

    // load every channel field when the write is taken
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            exp_out <= '0;
            took_q <= 1'b0;
        end else begin
            took_q <= write_in && !took_q;
            if (write_in && !took_q) begin
                exp_out <= data_in;
            end
        end
    end
endmodule : chan_reg_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench of the analog setting write and read-back ports
// assumes the constants header is in the include path; four channels
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ****************************************
    // stimulus and observation
    // ****************************************
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wr = 1'b0;
    logic lae = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [99:0] wd = '0; // packed write data, channel 0 lowest
    logic [99:0] d;
    wire [99:0] rb;
    wire [99:0] exp_rb;
    wire [11:0] rb2;
    wire busy;
    wire err;
    int num_errors = 0;
    int total_checks = 0;

    // 125 MHz clock
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    pma_analog_setting_rw_ports dut_u (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .write_in(wr),
        .logical_addr_en_in(lae), .chan_addr_in(addr),
        .swing_write_in(wd[11:0]), .pretap_write_in(wd[31:12]),
        .post1_tap_write_in(wd[51:32]), .post2_tap_write_in(wd[71:52]),
        .eq_write_in(wd[87:72]), .dcgain_write_in(wd[99:88]),
        .busy_out(busy), .dcgain_code_err_out(err),
        .swing_readback_out(rb[11:0]), .pretap_readback_out(rb[31:12]),
        .post1_tap_readback_out(rb[51:32]), .post2_tap_readback_out(rb[71:52]),
        .eq_readback_out(rb[87:72]), .dcgain_readback_out(rb[99:88])
    );

    // shared-field variant: field 0 fans out to the channels
    pma_analog_setting_rw_ports #(.SHARED_CTRL(1'b1)) dut_s (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .write_in(wr),
        .logical_addr_en_in(lae), .chan_addr_in(addr),
        .swing_write_in(wd[2:0]), .pretap_write_in(wd[16:12]),
        .post1_tap_write_in(wd[36:32]), .post2_tap_write_in(wd[56:52]),
        .eq_write_in(wd[75:72]), .dcgain_write_in(wd[90:88]),
        .busy_out(), .dcgain_code_err_out(), .swing_readback_out(),
        .pretap_readback_out(), .post1_tap_readback_out(),
        .post2_tap_readback_out(), .eq_readback_out(), .dcgain_readback_out(rb2)
    );

    chan_reg_model model_u (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .write_in(wr),
        .data_in(wd), .exp_out(exp_rb)
    );

    // ****************************************
    // tasks
    // ****************************************
    task chk_vec(input string name, input logic [99:0] e, input logic [99:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk_vec

    // one write; busy is looked at in the commit cycle, read-backs settle after it
    task do_write(input logic [99:0] v);
        @(negedge mclk_in);
        wd = v;
        wr = 1'b1;
        @(negedge mclk_in);
        wr = 1'b0;
        chk_vec("busy_out", 100'h1, {99'h0, busy});
        @(negedge mclk_in);
    endtask : do_write

    task print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(negedge mclk_in);
        rstn_in = 1'b1;
        @(negedge mclk_in);
        chk_vec("readback", 100'h0, rb);
        chk_vec("err", 100'h0, {99'h0, err});
        $display("test reset values done");
        // every legal code reaches every channel, fields kept apart
        for (int k = 0; k < 5; k++) begin
            d = {12'h0, {11{8'(k * 29 + 53)}}};
            for (int i = 0; i < 4; i++) begin
                d[88 + 3 * i +: 3] = 3'((k + i) % 5);
            end
            do_write(d);
            chk_vec("readback", exp_rb, rb);
        end
        chk_vec("err", 100'h0, {99'h0, err});
        $display("test legal codes done");
        // a request in the commit cycle is dropped
        @(negedge mclk_in);
        wd = {12'h123, {11{8'h5a}}};
        wr = 1'b1;
        @(negedge mclk_in);
        wd = {12'h444, {11{8'ha5}}};
        @(negedge mclk_in);
        wr = 1'b0;
        @(negedge mclk_in);
        chk_vec("refused", {12'h123, {11{8'h5a}}}, rb);
        $display("test back to back done");
        // an undefined code sets the sticky flag; code 5 sits in channel 0
        do_write({12'h005, {11{8'h0f}}});
        chk_vec("err", 100'h1, {99'h0, err});
        chk_vec("readback", exp_rb, rb);
        do_write({12'h000, {11{8'h00}}});
        chk_vec("err", 100'h1, {99'h0, err});
        $display("test undefined code done");
        // shared field to all channels, then to one addressed channel
        do_write({12'h003, 88'h0});
        chk_vec("shared", 100'h6db, {88'h0, rb2});
        lae = 1'b1;
        addr = 2'h2;
        do_write({12'h001, 88'h0});
        chk_vec("addressed", 100'h65b, {88'h0, rb2});
        $display("test shared field done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
